/* File: rtl/rinse_cal_seq.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// (R1) Start a rinse whenever the programmed interval comes due.
// (R2) When enabled, start a rinse when the reading falls below threshold.
// (R3) Optional alarm when a low-triggered rinse leaves the reading low.
// (R4) During any sequence freeze alarms, show hold and sequence active.
// (R5) Config bit freezes analog outputs or not; hold shows either way.
// (R6) Keep readable seconds remaining while a sequence runs.
// (R7) Drive rinse valve for rinse time, 1 to 1999 seconds.
// (R8) Divert valve, if enabled, follows the rinse valve exactly.
// (R9) After rinse release valves, wait settle time 1 to 1999 seconds.
// (R10) Settle end restores normal operation, clears hold and active.
// (R11) Pause key toggles suspension; abandon sequence after 20 minutes paused.
// (R12) Calibration always begins with the full rinse phase.
// (R13) After rinse drive first buffer valve up to buffer time.
// (R14) First buffer ends on stability or timeout, then zero captured.
// (R15) Failed diagnostic always flags error; alarm only if configured.
// (R16) Out-of-limits result discarded, previous value kept.
// (R17) Release all valves before the settle delay.
// (R18) Count standardisations; at programmed count add slope step.
// (R19) Slope step drives second buffer valve for buffer time.
// (R20) Second buffer ends on stability or timeout; slope stored if accepted.
// (R21) Ignore triggers while a sequence is running.
module rinse_cal_seq
  import rinse_cal_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = rinse_cal_pkg::TICK_CYCLES_1S
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Measurement side
  input wire logic [15:0] measured_value,
  input wire logic stable_reading,
  input wire logic [15:0] cal_result,
  input wire logic cal_diag_ok,
  // Operator pin
  input wire logic pause_key,
  // Valves and indications
  output logic rinse_valve,
  output logic drain_divert_valve,
  output logic first_buffer_valve,
  output logic second_buffer_valve,
  output logic sequence_active_indication,
  output logic hold_indication,
  output logic freeze_outputs,
  output logic freeze_alarms,
  output logic low_reading_alarm,
  output logic diag_alarm
);
  import rinse_cal_pkg::*;

  // ==========================================
  // Registers
  // ==========================================
  ctrl_s ctrl_reg;
  logic [23:0] interval_reg;
  logic [10:0] rinse_reg, settle_reg, buffer_reg;
  logic [7:0] slope_every_reg;
  logic [15:0] threshold_reg;
  logic [15:0] zero_reg, slope_reg;
  logic diag_err_reg, low_err_reg;
  logic [12:0] remain_reg;
  seq_state_e state_reg;
  logic [10:0] timer_reg;
  logic is_cal_reg, low_seq_reg, paused_reg;
  logic [10:0] pause_cnt_reg;
  logic [7:0] std_cnt_reg;
  logic [23:0] sched_cnt_reg;
  logic [25:0] div_reg;
  logic tick_reg;
  logic pause_s1_reg, pause_s2_reg, pause_s3_reg;
  logic below_prev_reg;
  logic aw_full_reg, w_full_reg;
  logic [5:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;

  logic wr_fire, cmd_rinse, cmd_cal, clr_diag, clr_low;
  logic below, start_low, sched_due, start_any, start_cal;
  logic run, phase_done, abandon, slope_due, buf_end, press;
  logic [10:0] rinse_d, settle_d, buffer_d;

  assign rinse_d = clamp_dur(rinse_reg);
  assign settle_d = clamp_dur(settle_reg);
  assign buffer_d = clamp_dur(buffer_reg);

  // ==========================================
  // Seconds tick and pause key
  // ==========================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg <= '0;
      tick_reg <= 1'b0;
    end else if (div_reg == 26'(TICK_CYCLES - 1)) begin
      div_reg <= '0;
      tick_reg <= 1'b1;
    end else begin
      div_reg <= div_reg + 26'h000_0001;
      tick_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pause_s1_reg <= 1'b0;
      pause_s2_reg <= 1'b0;
      pause_s3_reg <= 1'b0;
    end else begin
      pause_s1_reg <= pause_key;
      pause_s2_reg <= pause_s1_reg;
      pause_s3_reg <= pause_s2_reg;
    end
  end
  assign press = pause_s2_reg && !pause_s3_reg;

  // ==========================================
  // Triggers
  // ==========================================
  assign below = measured_value < threshold_reg;
  // (R2) low crossing
  assign start_low = ctrl_reg.low_trig_en && below && !below_prev_reg;
  // (R1) interval due
  assign sched_due = ctrl_reg.sched_en && tick_reg && (sched_cnt_reg + 24'h00_0001 >= interval_reg);
  assign start_cal = cmd_cal || (sched_due && ctrl_reg.cal_en);
  assign start_any = sched_due || start_low || cmd_rinse || cmd_cal;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      below_prev_reg <= 1'b0;
      sched_cnt_reg <= '0;
    end else begin
      below_prev_reg <= below;
      if (!ctrl_reg.sched_en || sched_due) begin
        sched_cnt_reg <= '0;
      end else if (tick_reg) begin
        sched_cnt_reg <= sched_cnt_reg + 24'h00_0001;
      end
    end
  end

  // ==========================================
  // Sequencer
  // ==========================================
  assign run = state_reg != ST_IDLE;
  assign phase_done = run && tick_reg && !paused_reg && timer_reg == DUR_MIN;
  assign abandon = paused_reg && tick_reg && pause_cnt_reg == 11'(PAUSE_LIMIT_S - 1);
  assign slope_due = slope_every_reg != '0 && (std_cnt_reg + 8'h01 >= slope_every_reg);
  assign buf_end = (state_reg == ST_BUF1 || state_reg == ST_BUF2)
                   && !paused_reg && (stable_reading || phase_done);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      timer_reg <= '0;
      is_cal_reg <= 1'b0;
      low_seq_reg <= 1'b0;
    end else if (abandon) begin
      // (R11) give up after long pause
      state_reg <= ST_IDLE;
      timer_reg <= '0;
    end else begin
      if (run && tick_reg && !paused_reg && timer_reg != '0) begin
        timer_reg <= timer_reg - DUR_MIN;
      end
      case (state_reg)
        ST_IDLE: begin
          // (R12) every sequence opens with rinse
          if (start_any) begin
            state_reg <= ST_RINSE;
            timer_reg <= rinse_d;
            is_cal_reg <= start_cal;
            low_seq_reg <= start_low;
          end
        end
        ST_RINSE: begin
          // (R9) rinse done, settle or buffer
          if (phase_done && is_cal_reg) begin
            state_reg <= ST_BUF1;
            timer_reg <= buffer_d;
          end else if (phase_done) begin
            state_reg <= ST_SETTLE;
            timer_reg <= settle_d;
          end
        end
        ST_BUF1: begin
          // (R18) slope step at programmed count
          if (buf_end && slope_due) begin
            state_reg <= ST_BUF2;
            timer_reg <= buffer_d;
          end else if (buf_end) begin
            state_reg <= ST_SETTLE;
            timer_reg <= settle_d;
          end
        end
        ST_BUF2: begin
          // (R20) stability or timeout
          if (buf_end) begin
            state_reg <= ST_SETTLE;
            timer_reg <= settle_d;
          end
        end
        ST_SETTLE: begin
          // (R10) back to normal
          if (phase_done) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // (R11) pause toggles and is timed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      paused_reg <= 1'b0;
      pause_cnt_reg <= '0;
    end else if (!run || abandon) begin
      paused_reg <= 1'b0;
      pause_cnt_reg <= '0;
    end else begin
      if (press) begin
        paused_reg <= !paused_reg;
        pause_cnt_reg <= '0;
      end else if (paused_reg && tick_reg) begin
        pause_cnt_reg <= pause_cnt_reg + 11'h001;
      end
    end
  end

  // (R14) capture zero, (R20) capture slope, (R16) reject bad values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      zero_reg <= '0;
      slope_reg <= '0;
      std_cnt_reg <= '0;
    end else if (buf_end) begin
      if (state_reg == ST_BUF1) begin
        std_cnt_reg <= slope_due ? 8'h00 : std_cnt_reg + 8'h01;
        if (cal_diag_ok) begin
          zero_reg <= cal_result;
        end
      end else if (cal_diag_ok) begin
        slope_reg <= cal_result;
      end
    end
  end

  // (R15) error flag, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      diag_err_reg <= 1'b0;
    end else if (buf_end && !cal_diag_ok) begin
      diag_err_reg <= 1'b1;
    end else if (clr_diag) begin
      diag_err_reg <= 1'b0;
    end
  end

  // (R3) low reading remains after its rinse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_err_reg <= 1'b0;
    end else if (state_reg == ST_SETTLE && phase_done && low_seq_reg
                 && below && ctrl_reg.low_alarm_en) begin
      low_err_reg <= 1'b1;
    end else if (clr_low) begin
      low_err_reg <= 1'b0;
    end
  end

  // ==========================================
  // Valves and indications
  // ==========================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rinse_valve <= 1'b0;
      drain_divert_valve <= 1'b0;
      first_buffer_valve <= 1'b0;
      second_buffer_valve <= 1'b0;
    end else begin
      // (R7) rinse valve, (R8) divert tied to it
      rinse_valve <= state_reg == ST_RINSE;
      drain_divert_valve <= state_reg == ST_RINSE && ctrl_reg.divert_en;
      // (R13) first buffer, (R19) second buffer, (R17) none in settle
      first_buffer_valve <= state_reg == ST_BUF1;
      second_buffer_valve <= state_reg == ST_BUF2;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sequence_active_indication <= 1'b0;
      hold_indication <= 1'b0;
      freeze_outputs <= 1'b0;
      freeze_alarms <= 1'b0;
    end else begin
      // (R4) hold and active, (R5) output freeze per config
      sequence_active_indication <= run;
      hold_indication <= run;
      freeze_alarms <= run;
      freeze_outputs <= run && ctrl_reg.hold_outputs;
    end
  end

  // Alarm pins follow flags only outside a sequence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_reading_alarm <= 1'b0;
      diag_alarm <= 1'b0;
    end else if (!run) begin
      // (R4) alarms frozen while running, (R15) alarm only if enabled
      low_reading_alarm <= low_err_reg;
      diag_alarm <= diag_err_reg && ctrl_reg.diag_alarm_en;
    end
  end

  // (R6) remaining time of the whole sequence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remain_reg <= '0;
    end else begin
      case (state_reg)
        ST_RINSE: remain_reg <= 13'(timer_reg) + 13'(settle_d)
            + (is_cal_reg ? 13'(buffer_d) + (slope_due ? 13'(buffer_d) : 13'h0000) : 13'h0000);
        ST_BUF1: remain_reg <= 13'(timer_reg) + 13'(settle_d)
            + (slope_due ? 13'(buffer_d) : 13'h0000);
        ST_BUF2: remain_reg <= 13'(timer_reg) + 13'(settle_d);
        ST_SETTLE: remain_reg <= 13'(timer_reg);
        default: remain_reg <= '0;
      endcase
    end
  end

  // ==========================================
  // AXI4-Lite write
  // ==========================================
  assign wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;
  // (R21) commands only act when idle
  assign cmd_rinse = wr_fire && awaddr_reg == OFS_CMD && wstrb_reg[0]
                     && wdata_reg[CMD_RINSE_BIT] && !run;
  assign cmd_cal = wr_fire && awaddr_reg == OFS_CMD && wstrb_reg[0]
                   && wdata_reg[CMD_CAL_BIT] && !run;
  assign clr_diag = wr_fire && awaddr_reg == OFS_STATUS && wstrb_reg[0]
                    && wdata_reg[ST_DIAG_BIT];
  assign clr_low = wr_fire && awaddr_reg == OFS_STATUS && wstrb_reg[0]
                   && wdata_reg[ST_LOW_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        awaddr_reg <= {s_axi_awaddr[5:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= awaddr_reg > OFS_CMD ? RESP_SLVERR : RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RST;
      interval_reg <= INTERVAL_RST;
      rinse_reg <= RINSE_RST;
      settle_reg <= SETTLE_RST;
      buffer_reg <= BUFFER_RST;
      slope_every_reg <= SLOPE_EVERY_RST;
      threshold_reg <= THRESHOLD_RST;
    end else if (wr_fire) begin
      if (awaddr_reg == OFS_CTRL) begin
        ctrl_reg <= 7'(merge(32'(ctrl_reg), wdata_reg, wstrb_reg));
      end else if (awaddr_reg == OFS_INTERVAL) begin
        interval_reg <= 24'(merge(32'(interval_reg), wdata_reg, wstrb_reg));
      end else if (awaddr_reg == OFS_RINSE) begin
        rinse_reg <= 11'(merge(32'(rinse_reg), wdata_reg, wstrb_reg));
      end else if (awaddr_reg == OFS_SETTLE) begin
        settle_reg <= 11'(merge(32'(settle_reg), wdata_reg, wstrb_reg));
      end else if (awaddr_reg == OFS_BUFFER) begin
        buffer_reg <= 11'(merge(32'(buffer_reg), wdata_reg, wstrb_reg));
      end else if (awaddr_reg == OFS_SLOPE_EVERY) begin
        slope_every_reg <= 8'(merge(32'(slope_every_reg), wdata_reg, wstrb_reg));
      end else if (awaddr_reg == OFS_THRESHOLD) begin
        threshold_reg <= 16'(merge(32'(threshold_reg), wdata_reg, wstrb_reg));
      end
    end
  end

  // ==========================================
  // AXI4-Lite read
  // ==========================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      if (s_axi_araddr[5:2] == OFS_CTRL[5:2]) begin
        s_axi_rdata <= 32'(ctrl_reg);
      end else if (s_axi_araddr[5:2] == OFS_INTERVAL[5:2]) begin
        s_axi_rdata <= 32'(interval_reg);
      end else if (s_axi_araddr[5:2] == OFS_RINSE[5:2]) begin
        s_axi_rdata <= 32'(rinse_reg);
      end else if (s_axi_araddr[5:2] == OFS_SETTLE[5:2]) begin
        s_axi_rdata <= 32'(settle_reg);
      end else if (s_axi_araddr[5:2] == OFS_BUFFER[5:2]) begin
        s_axi_rdata <= 32'(buffer_reg);
      end else if (s_axi_araddr[5:2] == OFS_SLOPE_EVERY[5:2]) begin
        s_axi_rdata <= 32'(slope_every_reg);
      end else if (s_axi_araddr[5:2] == OFS_THRESHOLD[5:2]) begin
        s_axi_rdata <= 32'(threshold_reg);
      end else if (s_axi_araddr[5:2] == OFS_STATUS[5:2]) begin
        s_axi_rdata <= {21'h00_0000, 3'(state_reg), 3'h0, paused_reg, run,
                        run, low_err_reg, diag_err_reg};
      end else if (s_axi_araddr[5:2] == OFS_REMAIN[5:2]) begin
        s_axi_rdata <= 32'(remain_reg);
      end else if (s_axi_araddr[5:2] == OFS_ZERO[5:2]) begin
        s_axi_rdata <= 32'(zero_reg);
      end else if (s_axi_araddr[5:2] == OFS_SLOPE[5:2]) begin
        s_axi_rdata <= 32'(slope_reg);
      end else if (s_axi_araddr[5:2] == OFS_CMD[5:2]) begin
        s_axi_rdata <= '0;
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================
  // Checks
  // ==========================================
  a_divert_with_rinse: // (R8)
    assert property (@(posedge aclk) disable iff (!aresetn)
      drain_divert_valve |-> rinse_valve)
    else $error("divert valve on without rinse valve");
  a_buffer_after_rinse: // (R12)
    assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(first_buffer_valve) |-> $past(rinse_valve))
    else $error("buffer valve opened without preceding rinse");
  a_alarms_frozen: // (R4)
    assert property (@(posedge aclk) disable iff (!aresetn)
      sequence_active_indication && $past(sequence_active_indication)
      |-> $stable(low_reading_alarm) && $stable(diag_alarm))
    else $error("alarm output moved during a sequence");
  a_freeze_in_seq: // (R5)
    assert property (@(posedge aclk) disable iff (!aresetn)
      freeze_outputs |-> hold_indication && sequence_active_indication)
    else $error("outputs frozen outside a sequence");
  a_settle_valves_off: // (R17)
    assert property (@(posedge aclk) disable iff (!aresetn)
      state_reg == ST_SETTLE |=> !(rinse_valve || first_buffer_valve
      || second_buffer_valve || drain_divert_valve))
    else $error("valve energised during settle");
  a_settle_end_clear: // (R10)
    assert property (@(posedge aclk) disable iff (!aresetn)
      state_reg == ST_SETTLE && phase_done && !abandon
      |=> state_reg == ST_IDLE ##1 !sequence_active_indication && !hold_indication)
    else $error("hold not cleared after settle");
  a_pause_abandon: // (R11)
    assert property (@(posedge aclk) disable iff (!aresetn)
      abandon |=> state_reg == ST_IDLE ##1 !sequence_active_indication)
    else $error("long pause did not end the sequence");
  a_reject_bad_cal: // (R16)
    assert property (@(posedge aclk) disable iff (!aresetn)
      buf_end && !cal_diag_ok |=> $stable(zero_reg) && $stable(slope_reg) && diag_err_reg)
    else $error("rejected calibration changed stored value");
  a_no_retrigger: // (R21)
    assert property (@(posedge aclk) disable iff (!aresetn)
      state_reg == ST_RINSE && !phase_done && !abandon |=> state_reg == ST_RINSE)
    else $error("rinse phase disturbed by a trigger");
endmodule
`default_nettype wire

/* File: common/rinse_cal_pkg.sv */
`default_nettype none
package rinse_cal_pkg;
  // ==========================================
  // Timing
  // ==========================================
  localparam int CLK_HZ = 50_000_000;
  localparam int SECOND_S = 1;
  localparam int TICK_CYCLES_1S = CLK_HZ * SECOND_S;
  localparam int PAUSE_LIMIT_MIN = 20;
  localparam int PAUSE_LIMIT_S = PAUSE_LIMIT_MIN * 60;
  localparam logic [10:0] DUR_MIN = 11'h001;
  localparam logic [10:0] DUR_MAX = 11'h7CF;
  // ==========================================
  // Register offsets
  // ==========================================
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_INTERVAL = 6'h04;
  localparam logic [5:0] OFS_RINSE = 6'h08;
  localparam logic [5:0] OFS_SETTLE = 6'h0C;
  localparam logic [5:0] OFS_BUFFER = 6'h10;
  localparam logic [5:0] OFS_SLOPE_EVERY = 6'h14;
  localparam logic [5:0] OFS_THRESHOLD = 6'h18;
  localparam logic [5:0] OFS_STATUS = 6'h1C;
  localparam logic [5:0] OFS_REMAIN = 6'h20;
  localparam logic [5:0] OFS_ZERO = 6'h24;
  localparam logic [5:0] OFS_SLOPE = 6'h28;
  localparam logic [5:0] OFS_CMD = 6'h2C;
  // ==========================================
  // Fields and reset values
  // ==========================================
  localparam int ST_DIAG_BIT = 0;
  localparam int ST_LOW_BIT = 1;
  localparam int CMD_RINSE_BIT = 0;
  localparam int CMD_CAL_BIT = 1;
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [23:0] INTERVAL_RST = 24'h00_0E10;
  localparam logic [10:0] RINSE_RST = 11'h01E;
  localparam logic [10:0] SETTLE_RST = 11'h01E;
  localparam logic [10:0] BUFFER_RST = 11'h03C;
  localparam logic [7:0] SLOPE_EVERY_RST = 8'h00;
  localparam logic [15:0] THRESHOLD_RST = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic diag_alarm_en;
    logic hold_outputs;
    logic divert_en;
    logic low_alarm_en;
    logic low_trig_en;
    logic cal_en;
    logic sched_en;
  } ctrl_s;

  typedef enum {ST_IDLE, ST_RINSE, ST_BUF1, ST_BUF2, ST_SETTLE} seq_state_e;

  // Durations are kept inside 1..1999 seconds
  function automatic logic [10:0] clamp_dur(input logic [10:0] d);
    if (d < DUR_MIN) begin
      return DUR_MIN;
    end else if (d > DUR_MAX) begin
      return DUR_MAX;
    end
    return d;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction
endpackage
`default_nettype wire

/* File: tb/valve_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module valve_partner (
  // Clock and valves
  input wire logic aclk,
  input wire logic rinse_valve,
  input wire logic drain_divert_valve,
  input wire logic first_buffer_valve,
  input wire logic second_buffer_valve,
  // Operator side
  input wire logic press,
  output logic pause_key,
  output int rinse_on,
  output int divert_on,
  output int buf_on,
  output int overlap
);
  initial begin
    pause_key = 1'b0;
    {rinse_on, divert_on, buf_on, overlap} = '0;
  end
  always @(posedge aclk) begin
    pause_key <= press;
    rinse_on <= rinse_on + int'(rinse_valve);
    divert_on <= divert_on + int'(drain_divert_valve);
    buf_on <= buf_on + int'(first_buffer_valve | second_buffer_valve);
    if (rinse_valve && (first_buffer_valve || second_buffer_valve)) overlap <= overlap + 1;
  end
endmodule
`default_nettype wire

/* File: tb/auto_rinse_calibration_sequencer_test.sv */
`timescale 1ns/1ps
`default_nettype none
module auto_rinse_calibration_sequencer_test;
  import rinse_cal_pkg::*;
  localparam int T = 10;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, stable_reading = 0, cal_diag_ok = 1, press = 0;
  logic [5:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [15:0] measured_value = 16'hFFFF, cal_result = 16'h0000;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pause_key;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic rinse_valve, drain_divert_valve, first_buffer_valve, second_buffer_valve;
  logic sequence_active_indication, hold_indication, freeze_outputs, freeze_alarms;
  logic low_reading_alarm, diag_alarm;
  int bad_count = 0, compares = 0, seed = 6573, r0, b0, rinse_on, divert_on, buf_on, overlap;
  int zero_m;
  rinse_cal_seq #(.TICK_CYCLES(T)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .measured_value, .stable_reading, .cal_result,
    .cal_diag_ok, .pause_key, .rinse_valve, .drain_divert_valve, .first_buffer_valve,
    .second_buffer_valve, .sequence_active_indication, .hold_indication, .freeze_outputs,
    .freeze_alarms, .low_reading_alarm, .diag_alarm);
  valve_partner far (.aclk, .rinse_valve, .drain_divert_valve, .first_buffer_valve,
    .second_buffer_valve, .press, .pause_key, .rinse_on, .divert_on, .buf_on, .overlap);
  initial forever #10 aclk = ~aclk;
  // ==========================================
  // Shared tasks
  // ==========================================
  task final_report;
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task wr(input logic [5:0] a, input logic [31:0] d);
    int n;
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 50) begin bad_count++; final_report; end
    @(posedge aclk);
  endtask
  task rdr(input logic [5:0] a);
    int n;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    {rd, rr} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
    if (n == 50) begin bad_count++; final_report; end
    @(posedge aclk);
  endtask
  task act(input logic lvl);
    int n;
    for (n = 0; n < 400 && sequence_active_indication !== lvl; n++) @(posedge aclk);
    if (n == 400) begin bad_count++; final_report; end
  endtask
  task run(input logic [31:0] c);
    wr(OFS_CMD, c);
    act(1'b1);
  endtask
  // ==========================================
  // Scenarios
  // ==========================================
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdr(OFS_RINSE);
    chk(rd, 32'(RINSE_RST), "rinse reset");
    rdr(6'h30);
    chk(rr, RESP_SLVERR, "unmapped");
    chk(rinse_valve | hold_indication, 0, "idle outputs");
    wr(OFS_RINSE, 2);
    wr(OFS_SETTLE, 1);
    wr(OFS_BUFFER, 2);
    wr(OFS_SLOPE_EVERY, 1);
    wr(OFS_CTRL, 32'h0000_0072);
    r0 = rinse_on;
    run(1);
    chk({hold_indication, freeze_outputs, freeze_alarms}, 3'b111, "hold");
    wr(OFS_CMD, 2);
    rdr(OFS_REMAIN);
    chk(rd > 0 && rd <= 3, 1, "remain");
    act(1'b0);
    chk((rinse_on - r0) inside {[T:2*T+2]}, 1, "rinse time");
    chk(divert_on, rinse_on, "divert");
    chk(buf_on, 0, "trigger ignored");
    chk(hold_indication, 0, "hold cleared");
    $display("rinse test done");
    zero_m = $random(seed) & 32'h0000_FFFF;
    cal_result <= 16'(zero_m);
    b0 = buf_on;
    run(2);
    act(1'b0);
    chk((buf_on - b0) inside {[2*T:4*T+4]}, 1, "buffer time");
    chk(overlap, 0, "valve order");
    rdr(OFS_ZERO);
    chk(rd[15:0], zero_m[15:0], "zero");
    rdr(OFS_SLOPE);
    chk(rd[15:0], zero_m[15:0], "slope");
    $display("calibration test done");
    {cal_diag_ok, stable_reading} <= 2'b01;
    cal_result <= ~16'(zero_m);
    b0 = buf_on;
    run(2);
    act(1'b0);
    chk(buf_on - b0 < T, 1, "stable end");
    rdr(OFS_ZERO);
    chk(rd[15:0], zero_m[15:0], "zero kept");
    rdr(OFS_STATUS);
    chk(rd[ST_DIAG_BIT], 1, "diag flag");
    chk(diag_alarm, 1, "diag alarm");
    wr(OFS_THRESHOLD, 16);
    wr(OFS_CTRL, 32'h0000_000C);
    measured_value <= 16'h0004;
    act(1'b1);
    act(1'b0);
    chk(low_reading_alarm, 1, "low alarm");
    chk(diag_alarm, 0, "alarm disabled");
    $display("diagnostic test done");
    run(1);
    press <= 1'b1;
    repeat (4) @(posedge aclk);
    press <= 1'b0;
    repeat (4 * T) @(posedge aclk);
    chk(rinse_valve, 1, "paused");
    press <= 1'b1;
    repeat (4) @(posedge aclk);
    press <= 1'b0;
    act(1'b0);
    chk(rinse_valve, 0, "resumed");
    run(1);
    press <= 1'b1;
    repeat (4) @(posedge aclk);
    press <= 1'b0;
    repeat ((PAUSE_LIMIT_S - 2) * T) @(posedge aclk);
    chk(rinse_valve, 1, "long pause");
    act(1'b0);
    chk(rinse_valve, 0, "abandoned");
    $display("pause test done");
    final_report;
  end
endmodule
`default_nettype wire
